// ### src/slp_ctrl.sv
module slp_ctrl #(
  parameter int PIN_WIDTH = slp_pkg::SLP_PIN_WIDTH,
  parameter int CNT_WIDTH = slp_pkg::SLP_CNT_WIDTH,
  parameter int OSC_START_CYCLES = slp_pkg::SLP_OSC_START_CYCLES,
  parameter int FAST_START_CYCLES = slp_pkg::SLP_FAST_START_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic sleep_en,
  input wire logic sleep_req,
  input wire logic [2:0] sleep_mode,
  input wire logic [PIN_WIDTH-1:0] pin_in,
  input wire logic [PIN_WIDTH-1:0] pin_mask,
  input wire logic pcint_ack,
  input wire slp_pkg::slp_wake_src_t wake_src,
  output slp_pkg::slp_clk_en_t clk_en,
  output logic cpu_run,
  output logic sleeping,
  output logic pcint_flag,
  output logic [2:0] active_mode
);
  import slp_pkg::*;

  localparam int AST_WAKE_MAX = OSC_START_CYCLES + 2;
  localparam int AST_FAST_MAX = FAST_START_CYCLES + 2;

  function automatic logic mode_valid(input logic [2:0] m);
    mode_valid = (m <= SLP_MODE_XSTBY);
  endfunction : mode_valid

  // clock domains that stay on while asleep in a given mode
  function automatic slp_clk_en_t mode_gates(input logic [2:0] m);
    slp_clk_en_t g;
    g = SLP_ALL_OFF;
    case (m)
      SLP_MODE_IDLE: begin
        g = SLP_ALL_ON;
        g.cpu = 1'b0;
      end
      SLP_MODE_ADCNR: begin
        g.adc = 1'b1;
        g.async_tmr = 1'b1;
        g.intr = 1'b1;
        g.main_osc = 1'b1;
        g.xtal_osc = 1'b1;
      end
      SLP_MODE_PSAVE: begin
        g.async_tmr = 1'b1;
      end
      SLP_MODE_PDOWN: begin
        g = SLP_ALL_OFF;
      end
      SLP_MODE_STBY: begin
        g.xtal_osc = 1'b1;
      end
      SLP_MODE_XSTBY: begin
        g.main_osc = 1'b1;
        g.xtal_osc = 1'b1;
        g.async_tmr = 1'b1;
      end
      default: begin
        g = SLP_ALL_ON;
      end
    endcase
    return g;
  endfunction : mode_gates

  // an oscillator that kept running allows the short start-up
  function automatic logic [CNT_WIDTH-1:0] start_len(input logic [2:0] m);
    slp_clk_en_t g;
    g = mode_gates(m);
    if (g.main_osc || g.xtal_osc) begin
      start_len = CNT_WIDTH'(FAST_START_CYCLES);
    end else begin
      start_len = CNT_WIDTH'(OSC_START_CYCLES);
    end
  endfunction : start_len

  slp_state_t state;
  slp_state_t next_state;
  logic [2:0] mode_q;
  logic [2:0] next_mode;
  logic [CNT_WIDTH-1:0] start_cnt;
  logic pc_event;
  logic enter;
  logic wake;
  slp_clk_en_t sleep_gates;
  slp_clk_en_t next_clk;

  slp_pin_change #(
    .WIDTH(PIN_WIDTH)
  ) u_pin_change (
    .mclk(mclk),
    .srst(srst),
    .pin_in(pin_in),
    .pin_mask(pin_mask),
    .irq_ack(pcint_ack),
    .irq_flag(pcint_flag),
    .change_event(pc_event)
  );

  assign sleep_gates = mode_gates(mode_q);
  assign enter = (state == SLP_ACTIVE) && sleep_en && sleep_req && mode_valid(sleep_mode);

  // pin change and external interrupt always wake the core; other sources only if their clock still runs in this mode
  always_comb begin
    wake = pc_event || wake_src.ext_irq;
    if (sleep_gates.async_tmr && wake_src.async_irq) begin
      wake = 1'b1;
    end
    if (sleep_gates.adc && wake_src.adc_irq) begin
      wake = 1'b1;
    end
    if (sleep_gates.io && wake_src.io_irq) begin
      wake = 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    next_mode = mode_q;
    case (state)
      SLP_ACTIVE: begin
        if (enter) begin
          next_state = SLP_SLEEP;
          next_mode = sleep_mode;
        end
      end
      SLP_SLEEP: begin
        if (wake) begin
          next_state = SLP_START;
        end
      end
      SLP_START: begin
        if (start_cnt <= CNT_WIDTH'(1)) begin
          next_state = SLP_ACTIVE;
        end
      end
      default: begin
        next_state = SLP_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= SLP_ACTIVE;
      mode_q <= SLP_MODE_IDLE;
    end else begin
      state <= next_state;
      mode_q <= next_mode;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      start_cnt <= '0;
    end else if (state == SLP_SLEEP && wake) begin
      start_cnt <= start_len(mode_q);
    end else if (state == SLP_START && start_cnt != '0) begin
      start_cnt <= start_cnt - CNT_WIDTH'(1);
    end
  end

  // gates follow the state they belong to in the same cycle
  always_comb begin
    next_clk = SLP_ALL_ON;
    case (next_state)
      SLP_ACTIVE: begin
        next_clk = SLP_ALL_ON;
      end
      SLP_SLEEP: begin
        next_clk = mode_gates(next_mode);
      end
      SLP_START: begin
        next_clk = mode_gates(next_mode);
        next_clk.main_osc = 1'b1;
        next_clk.xtal_osc = 1'b1;
      end
      default: begin
        next_clk = SLP_ALL_ON;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      clk_en <= SLP_ALL_ON;
      cpu_run <= 1'b1;
      sleeping <= 1'b0;
      active_mode <= SLP_MODE_IDLE;
    end else begin
      clk_en <= next_clk;
      cpu_run <= next_clk.cpu;
      sleeping <= (next_state == SLP_SLEEP);
      active_mode <= next_mode;
    end
  end

  AST_IDLE_GATES: assert property (@(posedge mclk) disable iff (srst)
    state == SLP_SLEEP && mode_q == SLP_MODE_IDLE |->
      !clk_en.cpu && clk_en.sram && clk_en.io && clk_en.intr)
    else $error("idle gating wrong");

  AST_PDOWN_GATES: assert property (@(posedge mclk) disable iff (srst)
    state == SLP_SLEEP && mode_q == SLP_MODE_PDOWN |-> clk_en == SLP_ALL_OFF)
    else $error("power-down left a clock running");

  AST_PSAVE_GATES: assert property (@(posedge mclk) disable iff (srst)
    state == SLP_SLEEP && mode_q == SLP_MODE_PSAVE |->
      clk_en.async_tmr && !clk_en.cpu && !clk_en.io && !clk_en.main_osc && !clk_en.adc)
    else $error("power-save gating wrong");

  AST_ADCNR_GATES: assert property (@(posedge mclk) disable iff (srst)
    state == SLP_SLEEP && mode_q == SLP_MODE_ADCNR |->
      clk_en.adc && clk_en.async_tmr && !clk_en.cpu && !clk_en.io)
    else $error("adc noise reduction gating wrong");

  AST_STBY_GATES: assert property (@(posedge mclk) disable iff (srst)
    state == SLP_SLEEP && mode_q == SLP_MODE_STBY |->
      clk_en.xtal_osc && !clk_en.cpu && !clk_en.async_tmr && !clk_en.io)
    else $error("standby gating wrong");

  AST_XSTBY_GATES: assert property (@(posedge mclk) disable iff (srst)
    state == SLP_SLEEP && mode_q == SLP_MODE_XSTBY |->
      clk_en.main_osc && clk_en.async_tmr && !clk_en.cpu)
    else $error("extended standby gating wrong");

  AST_ENTER: assert property (@(posedge mclk) disable iff (srst)
    enter |=> sleeping && !cpu_run && active_mode == $past(sleep_mode))
    else $error("valid sleep request not taken");

  AST_BAD_MODE: assert property (@(posedge mclk) disable iff (srst)
    state == SLP_ACTIVE && !mode_valid(sleep_mode) |=> !sleeping)
    else $error("invalid mode entered sleep");

  AST_WAKE: assert property (@(posedge mclk) disable iff (srst)
    state == SLP_SLEEP && wake |=> clk_en.main_osc ##[1:AST_WAKE_MAX] (cpu_run && clk_en == SLP_ALL_ON))
    else $error("wake did not restore the core in time");

  AST_FAST_WAKE: assert property (@(posedge mclk) disable iff (srst)
    state == SLP_SLEEP && wake && mode_q == SLP_MODE_STBY |-> ##[1:AST_FAST_MAX] cpu_run)
    else $error("standby wake not fast");

  AST_PIN_WAKE: assert property (@(posedge mclk) disable iff (srst)
    state == SLP_SLEEP && pc_event |=> state == SLP_START)
    else $error("pin change did not wake");

  AST_STAY_ASLEEP: assert property (@(posedge mclk) disable iff (srst)
    state == SLP_SLEEP && !wake |=> state == SLP_SLEEP && $stable(clk_en))
    else $error("left sleep without a wake event");
endmodule : slp_ctrl

// ### include/slp_pkg.sv
package slp_pkg;
  localparam logic [2:0] SLP_MODE_IDLE = 3'h0;
  localparam logic [2:0] SLP_MODE_ADCNR = 3'h1;
  localparam logic [2:0] SLP_MODE_PSAVE = 3'h2;
  localparam logic [2:0] SLP_MODE_PDOWN = 3'h3;
  localparam logic [2:0] SLP_MODE_STBY = 3'h4;
  localparam logic [2:0] SLP_MODE_XSTBY = 3'h5;

  localparam int SLP_PIN_WIDTH = 8;
  localparam int SLP_CNT_WIDTH = 16;
  localparam int SLP_OSC_START_CYCLES = 16;
  localparam int SLP_FAST_START_CYCLES = 1;

  typedef struct packed {
    logic cpu;
    logic sram;
    logic io;
    logic intr;
    logic adc;
    logic async_tmr;
    logic main_osc;
    logic xtal_osc;
  } slp_clk_en_t;

  typedef struct packed {
    logic ext_irq;
    logic async_irq;
    logic adc_irq;
    logic io_irq;
  } slp_wake_src_t;

  typedef enum logic [2:0] {
    SLP_ACTIVE = 3'h1,
    SLP_SLEEP = 3'h2,
    SLP_START = 3'h4
  } slp_state_t;

  localparam slp_clk_en_t SLP_ALL_ON = slp_clk_en_t'(8'hFF);
  localparam slp_clk_en_t SLP_ALL_OFF = slp_clk_en_t'(8'h00);
endpackage : slp_pkg

// ### src/slp_pin_change.sv
module slp_pin_change #(
  parameter int WIDTH = slp_pkg::SLP_PIN_WIDTH
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] pin_mask,
  input wire logic irq_ack,
  output logic irq_flag,
  output logic change_event
);
  import slp_pkg::*;

  logic [WIDTH-1:0] pin_prev;
  logic primed;

  // first sample after reset only primes the history, so no false edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_prev <= '0;
      primed <= 1'b0;
    end else begin
      pin_prev <= pin_in;
      primed <= 1'b1;
    end
  end

  assign change_event = primed && (|((pin_in ^ pin_prev) & pin_mask));

  // a new change wins over an acknowledge in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_flag <= 1'b0;
    end else if (change_event) begin
      irq_flag <= 1'b1;
    end else if (irq_ack) begin
      irq_flag <= 1'b0;
    end
  end

  AST_PIN_RAISE: assert property (@(posedge mclk) disable iff (srst)
    primed && ((pin_in ^ pin_prev) & pin_mask) != '0 |=> irq_flag)
    else $error("enabled pin change did not raise the flag");

  AST_PIN_MASKED: assert property (@(posedge mclk) disable iff (srst)
    !irq_flag && (((pin_in ^ pin_prev) & pin_mask) == '0) |=> !irq_flag)
    else $error("flag rose without an enabled pin change");

  AST_SET_WINS: assert property (@(posedge mclk) disable iff (srst)
    change_event && irq_ack |=> irq_flag)
    else $error("pin change lost against acknowledge");
endmodule : slp_pin_change

// ### bench/test_slp_ctrl.sv
module test_slp_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import slp_pkg::*;

  localparam int OSC_L = 5;

  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic sleep_en = 1'b1;
  logic sleep_req = 1'b0;
  logic [2:0] sleep_mode = 3'h0;
  logic [SLP_PIN_WIDTH-1:0] pin_in = 8'h00;
  logic [SLP_PIN_WIDTH-1:0] pin_mask = 8'h00;
  logic pcint_ack = 1'b0;
  slp_wake_src_t wake_src = '0;
  slp_clk_en_t clk_en;
  logic cpu_run;
  logic sleeping;
  logic pcint_flag;
  logic [2:0] active_mode;
  int errors = 0;
  int checked = 0;

  always #20 mclk = ~mclk;

  slp_ctrl #(
    .OSC_START_CYCLES(OSC_L)
  ) i_slp_ctrl (
    .mclk(mclk),
    .srst(srst),
    .sleep_en(sleep_en),
    .sleep_req(sleep_req),
    .sleep_mode(sleep_mode),
    .pin_in(pin_in),
    .pin_mask(pin_mask),
    .pcint_ack(pcint_ack),
    .wake_src(wake_src),
    .clk_en(clk_en),
    .cpu_run(cpu_run),
    .sleeping(sleeping),
    .pcint_flag(pcint_flag),
    .active_mode(active_mode)
  );

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  task automatic sleep_in(input logic [2:0] m);
    sleep_mode = m;
    sleep_req = 1'b1;
    tick(1);
    sleep_req = 1'b0;
  endtask : sleep_in

  task automatic give_verdict;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic test_reset;
    check("clk_en", 8'hFF, clk_en);
    check("cpu_run", 8'h01, 8'(cpu_run));
    check("sleeping", 8'h00, 8'(sleeping));
    check("pcint_flag", 8'h00, 8'(pcint_flag));
    check("active_mode", 8'h00, 8'(active_mode));
  endtask : test_reset

  // every mode: gates, ignored sources, wake source, start-up length
  task automatic test_modes;
    logic [7:0] gates [6];
    logic [3:0] good [6];
    logic [3:0] bad [6];
    int len;
    gates = '{8'h7F, 8'h1F, 8'h04, 8'h00, 8'h01, 8'h07};
    good = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h8, 4'h4};
    bad = '{4'h0, 4'h1, 4'h3, 4'h7, 4'h7, 4'h3};
    for (int m = 0; m < 6; m++) begin
      len = (m == 2 || m == 3) ? OSC_L : 1;
      sleep_in(m[2:0]);
      check("clk_en", gates[m], clk_en);
      check("sleeping", 8'h01, 8'(sleeping));
      check("cpu_run", 8'h00, 8'(cpu_run));
      check("active_mode", {5'h00, m[2:0]}, 8'(active_mode));
      wake_src = slp_wake_src_t'(bad[m]);
      tick(2);
      check("sleeping", 8'h01, 8'(sleeping));
      wake_src = slp_wake_src_t'(good[m]);
      tick(1);
      wake_src = '0;
      check("sleeping", 8'h00, 8'(sleeping));
      check("clk_en", gates[m] | 8'h03, clk_en);
      tick(len - 1);
      check("cpu_run", 8'h00, 8'(cpu_run));
      tick(1);
      check("clk_en", 8'hFF, clk_en);
      check("cpu_run", 8'h01, 8'(cpu_run));
    end
  endtask : test_modes

  task automatic test_refuse;
    sleep_en = 1'b0;
    sleep_in(3'h3);
    sleep_en = 1'b1;
    check("sleeping", 8'h00, 8'(sleeping));
    // one idle cycle so the request strobe is not lowered and raised at once
    tick(1);
    sleep_in(3'h6);
    check("sleeping", 8'h00, 8'(sleeping));
    check("clk_en", 8'hFF, clk_en);
    check("active_mode", 8'h05, 8'(active_mode));
    tick(1);
  endtask : test_refuse

  task automatic test_pin;
    pin_mask = 8'h01;
    sleep_in(3'h3);
    pin_in[7] = 1'b1;
    tick(2);
    check("sleeping", 8'h01, 8'(sleeping));
    check("pcint_flag", 8'h00, 8'(pcint_flag));
    pin_in[0] = 1'b1;
    tick(1);
    check("pcint_flag", 8'h01, 8'(pcint_flag));
    check("sleeping", 8'h00, 8'(sleeping));
    // a sleep request during start-up must be ignored
    sleep_req = 1'b1;
    tick(1);
    sleep_req = 1'b0;
    check("sleeping", 8'h00, 8'(sleeping));
    check("cpu_run", 8'h00, 8'(cpu_run));
    tick(OSC_L - 1);
    check("cpu_run", 8'h01, 8'(cpu_run));
    pcint_ack = 1'b1;
    pin_in[0] = 1'b0;
    tick(1);
    pcint_ack = 1'b0;
    check("pcint_flag", 8'h01, 8'(pcint_flag));
    tick(1);
    pcint_ack = 1'b1;
    tick(1);
    pcint_ack = 1'b0;
    check("pcint_flag", 8'h00, 8'(pcint_flag));
    tick(1);
    check("sleeping", 8'h00, 8'(sleeping));
  endtask : test_pin

  initial begin
    #(40 * 2000);
    errors++;
    give_verdict();
  end

  initial begin
    tick(2);
    srst = 1'b0;
    test_reset();
    test_modes();
    test_refuse();
    test_pin();
    give_verdict();
  end
endmodule : test_slp_ctrl
